// ==== ldr_top.sv ====
// Line differential restraint and trip decision after vector group shift.
//
// The placing of the registers and the plain strobed port were chosen for this implementation.
`timescale 1ns/1ns
// Function
// - Sides scale by 100/ratio each and add per phase.
// - Inward flow is positive on both sides so through load cancels.
// - Second harmonic restraint rises at once on a ratio above setting.
// - Fifth harmonic restraint rises on a ratio above its own setting.
// - Restraint high for 25 ms holds 15 ms after the ratio falls.
// - Restraint repeats per phase and harmonic, six statuses in all.
// - Phase restraints OR into general second and fifth restraints.
// - Differential, local and remote magnitudes are formed per phase.
// - Bias is the largest of the six local and remote magnitudes.
// - A phase starts when its differential enters the biased region.
// - A phase is unrestrained when its differential exceeds the limit.
// - Phase unrestrained decisions OR into a general unrestrained start.
// - Trips weigh starts, unrestrained starts, restraints and block.
// - A trip output per phase and one general trip output are driven.
// - A harmonic block output shows when harmonic restraint is active while a phase has a biased start.
module ldr_top #(
   parameter int QUAL_CYCLES = ldr_pkg::QUAL_CYC,
   parameter int DROP_CYCLES = ldr_pkg::DROP_CYC
) (
   input  wire logic                      mclk,           // Evaluation clock.
   input  wire logic                      rst,            // Sync reset.
   input  wire logic [7:0]                reg_addr,       // Register address.
   input  wire logic [31:0]               reg_wdata,      // Write data.
   input  wire logic                      reg_wr,         // Write strobe.
   input  wire logic                      reg_rd,         // Read strobe.
   output logic      [31:0]               reg_rdata,      // Read data.
   input  wire ldr_pkg::ldr_phasor_t [2:0] local_shifted,  // Local vectors.
   input  wire ldr_pkg::ldr_phasor_t [2:0] remote_shifted, // Remote vectors.
   input  wire ldr_pkg::ldr_phasor_t [2:0] diff_h2,        // 2nd harmonic.
   input  wire ldr_pkg::ldr_phasor_t [2:0] diff_h5,        // 5th harmonic.
   input  wire logic                      user_block_input, // Block.
   output logic      [2:0]                phase_trip_out,   // Phase trips.
   output logic                           general_trip_out, // Any trip.
   output logic                           harmonic_block_out, // Restraint.
   output logic                           general_h2_restraint, // 2nd OR.
   output logic                           general_h5_restraint, // 5th OR.
   output logic                           general_unr_start, // Unr OR.
   output logic      [2:0]                biased_start    // Phase starts.
);
   localparam int W  = ldr_pkg::WIDE_W;
   localparam int PW = ldr_pkg::PROD_W;

   logic [15:0]         local_ratio_percent;
   logic [15:0]         remote_ratio_percent;
   logic [7:0]          h2_set;
   logic [7:0]          h5_set;
   logic [W-1:0]        unr_limit;
   logic [W-1:0]        char_base;
   logic [7:0]          char_slope;
   logic [15:0]         local_scale;
   logic [15:0]         remote_scale;
   ldr_pkg::ldr_wide_t  [2:0] loc_a;
   ldr_pkg::ldr_wide_t  [2:0] rem_a;
   ldr_pkg::ldr_wide_t  [2:0] phase_differential;
   ldr_pkg::ldr_wide_t  [2:0] h2_a;
   ldr_pkg::ldr_wide_t  [2:0] h5_a;
   logic [2:0][W-1:0]   dmag;
   logic [2:0][W-1:0]   lmag;
   logic [2:0][W-1:0]   rmag;
   logic [2:0][W-1:0]   h2mag;
   logic [2:0][W-1:0]   h5mag;
   logic [2:0][W-1:0]   dmag_c;
   logic [W-1:0]        bias;
   logic [2:0]          h2_high;
   logic [2:0]          h5_high;
   logic [2:0]          h2_status;
   logic [2:0]          h5_status;
   ldr_pkg::ldr_decision_t dec;

   // Reciprocal of a percent ratio in 8-bit fraction; zero counts as one.
   function automatic logic [15:0] scale_of(input logic [15:0] r);
      logic [23:0] q;
      q = 24'(ldr_pkg::PCT_FULL << ldr_pkg::SCALE_SHIFT)
          / {8'h00, (r == 16'h0000) ? 16'h0001 : r};
      return q[15:0];
   endfunction

   function automatic logic signed [W-1:0] scale_part(
      input logic signed [15:0] x, input logic [15:0] s);
      logic signed [PW-1:0] p;
      p = PW'(x) * $signed(PW'(s));
      return p[W-1+ldr_pkg::SCALE_SHIFT:ldr_pkg::SCALE_SHIFT];
   endfunction

   // Magnitude estimate: larger part plus half the smaller part.
   function automatic logic [W-1:0] mag(input ldr_pkg::ldr_wide_t v);
      logic [W-1:0] a;
      logic [W-1:0] b;
      a = v.re[W-1] ? W'(-v.re) : W'(v.re);
      b = v.im[W-1] ? W'(-v.im) : W'(v.im);
      return (a > b) ? a + (b >> 1) : b + (a >> 1);
   endfunction

   function automatic ldr_pkg::ldr_wide_t widen(
      input ldr_pkg::ldr_phasor_t p);
      ldr_pkg::ldr_wide_t w;
      w.re = W'(p.re);
      w.im = W'(p.im);
      return w;
   endfunction

   // Settings registers.
   always_ff @(posedge mclk) begin
      if (rst) begin
         local_ratio_percent  <= ldr_pkg::RST_RATIO;
         remote_ratio_percent <= ldr_pkg::RST_RATIO;
         h2_set               <= ldr_pkg::RST_H2_SET;
         h5_set               <= ldr_pkg::RST_H5_SET;
         unr_limit            <= ldr_pkg::RST_UNR_LIMIT;
         char_base            <= ldr_pkg::RST_CHAR_BASE;
         char_slope           <= ldr_pkg::RST_CHAR_SLOPE;
      end else if (reg_wr) begin
         case (reg_addr)
            ldr_pkg::ADDR_LOCAL_RATIO:
               local_ratio_percent  <= reg_wdata[15:0];
            ldr_pkg::ADDR_REMOTE_RATIO:
               remote_ratio_percent <= reg_wdata[15:0];
            ldr_pkg::ADDR_H2_SET:       h2_set     <= reg_wdata[7:0];
            ldr_pkg::ADDR_H5_SET:       h5_set     <= reg_wdata[7:0];
            ldr_pkg::ADDR_UNR_LIMIT:    unr_limit  <= reg_wdata[W-1:0];
            ldr_pkg::ADDR_CHAR_BASE:    char_base  <= reg_wdata[W-1:0];
            ldr_pkg::ADDR_CHAR_SLOPE:   char_slope <= reg_wdata[7:0];
            default: ;
         endcase
      end
   end

   // The divide sits off the data path; a new ratio applies one cycle later.
   always_ff @(posedge mclk) begin
      if (rst) begin
         local_scale  <= ldr_pkg::SCALE_UNITY;
         remote_scale <= ldr_pkg::SCALE_UNITY;
      end else begin
         local_scale  <= scale_of(local_ratio_percent);
         remote_scale <= scale_of(remote_ratio_percent);
      end
   end

   // Read port: data stand only in the cycle after the strobe.
   always_ff @(posedge mclk) begin
      if (rst || !reg_rd) reg_rdata <= 32'h00000000;
      else begin
         case (reg_addr)
            ldr_pkg::ADDR_LOCAL_RATIO:  reg_rdata <= 32'(local_ratio_percent);
            ldr_pkg::ADDR_REMOTE_RATIO: reg_rdata <= 32'(remote_ratio_percent);
            ldr_pkg::ADDR_H2_SET:       reg_rdata <= 32'(h2_set);
            ldr_pkg::ADDR_H5_SET:       reg_rdata <= 32'(h5_set);
            ldr_pkg::ADDR_UNR_LIMIT:    reg_rdata <= 32'(unr_limit);
            ldr_pkg::ADDR_CHAR_BASE:    reg_rdata <= 32'(char_base);
            ldr_pkg::ADDR_CHAR_SLOPE:   reg_rdata <= 32'(char_slope);
            ldr_pkg::ADDR_STATUS: begin
               reg_rdata <= 32'h00000000;
               reg_rdata[ldr_pkg::ST_TRIP+:3]  <= phase_trip_out;
               reg_rdata[ldr_pkg::ST_START+:3] <= dec.start;
               reg_rdata[ldr_pkg::ST_UNR+:3]   <= dec.unr;
               reg_rdata[ldr_pkg::ST_H2+:3]    <= h2_status;
               reg_rdata[ldr_pkg::ST_H5+:3]    <= h5_status;
               reg_rdata[ldr_pkg::ST_GEN]      <= general_trip_out;
               reg_rdata[ldr_pkg::ST_HBLK]     <= harmonic_block_out;
            end
            default: reg_rdata <= 32'h00000000;
         endcase
      end
   end

   genvar i;
   generate
      for (i = 0; i < 3; i++) begin : g_phase
         always_ff @(posedge mclk) begin
            if (rst) begin
               loc_a[i]              <= '0;
               rem_a[i]              <= '0;
               phase_differential[i] <= '0;
               h2_a[i]               <= '0;
               h5_a[i]               <= '0;
            end else begin
               loc_a[i].re <= scale_part(local_shifted[i].re, local_scale);
               loc_a[i].im <= scale_part(local_shifted[i].im, local_scale);
               rem_a[i].re <= scale_part(remote_shifted[i].re, remote_scale);
               rem_a[i].im <= scale_part(remote_shifted[i].im, remote_scale);
               phase_differential[i].re <=
                  scale_part(local_shifted[i].re, local_scale)
                  + scale_part(remote_shifted[i].re, remote_scale);
               phase_differential[i].im <=
                  scale_part(local_shifted[i].im, local_scale)
                  + scale_part(remote_shifted[i].im, remote_scale);
               h2_a[i] <= widen(diff_h2[i]);
               h5_a[i] <= widen(diff_h5[i]);
            end
         end

         always_ff @(posedge mclk) begin
            if (rst) begin
               dmag[i]  <= '0;
               lmag[i]  <= '0;
               rmag[i]  <= '0;
               h2mag[i] <= '0;
               h5mag[i] <= '0;
            end else begin
               dmag[i]  <= mag(phase_differential[i]);
               lmag[i]  <= mag(loc_a[i]);
               rmag[i]  <= mag(rem_a[i]);
               h2mag[i] <= mag(h2_a[i]);
               h5mag[i] <= mag(h5_a[i]);
            end
         end

         always_ff @(posedge mclk) begin
            if (rst) begin
               dmag_c[i]  <= '0;
               h2_high[i] <= 1'b0;
               h5_high[i] <= 1'b0;
            end else begin
               dmag_c[i]  <= dmag[i];
               h2_high[i] <= PW'(h2mag[i]) * PW'(ldr_pkg::PCT_FULL)
                             > PW'(h2_set) * PW'(dmag[i]);
               h5_high[i] <= PW'(h5mag[i]) * PW'(ldr_pkg::PCT_FULL)
                             > PW'(h5_set) * PW'(dmag[i]);
            end
         end

         always_ff @(posedge mclk) begin
            if (rst) begin
               dec.start[i] <= 1'b0;
               dec.unr[i]   <= 1'b0;
            end else begin
               dec.start[i] <= PW'(dmag_c[i]) * PW'(ldr_pkg::PCT_FULL)
                  > PW'(char_base) * PW'(ldr_pkg::PCT_FULL)
                    + PW'(bias) * PW'(char_slope);
               dec.unr[i]   <= dmag_c[i] > unr_limit;
            end
         end

         ldr_restraint_timer #(
            .QUAL_CYCLES (QUAL_CYCLES),
            .DROP_CYCLES (DROP_CYCLES)
         ) u_h2 (
            .mclk   (mclk),
            .rst    (rst),
            .high   (h2_high[i]),
            .status (h2_status[i])
         );
         ldr_restraint_timer #(
            .QUAL_CYCLES (QUAL_CYCLES),
            .DROP_CYCLES (DROP_CYCLES)
         ) u_h5 (
            .mclk   (mclk),
            .rst    (rst),
            .high   (h5_high[i]),
            .status (h5_status[i])
         );
      end
   endgenerate

   always_ff @(posedge mclk) begin
      if (rst) bias <= '0;
      else begin
         logic [W-1:0] m;
         m = '0;
         for (int k = 0; k < 3; k++) begin
            if (lmag[k] > m) m = lmag[k];
            if (rmag[k] > m) m = rmag[k];
         end
         bias <= m;
      end
   end

   // Restraint is cross-phase: inrush in one phase holds the biased starts of all phases; unrestrained starts still trip.
   // decision inputs
   always_ff @(posedge mclk) begin
      if (rst) begin
         phase_trip_out   <= 3'h0;
         general_trip_out <= 1'b0;
      end else begin
         phase_trip_out <= ((dec.start & {3{~|{h2_status, h5_status}}})
                           | dec.unr) & {3{~user_block_input}};
         general_trip_out <= |(((dec.start & {3{~|{h2_status, h5_status}}})
                           | dec.unr)) & ~user_block_input;
      end
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         general_h2_restraint <= 1'b0;
         general_h5_restraint <= 1'b0;
         general_unr_start    <= 1'b0;
         harmonic_block_out   <= 1'b0;
         biased_start         <= 3'h0;
      end else begin
         general_h2_restraint <= |h2_status;
         general_h5_restraint <= |h5_status;
         general_unr_start    <= |dec.unr;
         harmonic_block_out   <= |{h2_status, h5_status} & |dec.start;
         biased_start         <= dec.start;
      end
   end

   default clocking cb @(posedge mclk); endclocking
   default disable iff (rst);

   a_block_no_trip: assert property (
      user_block_input |=> (phase_trip_out == 3'h0 && !general_trip_out))
      else $error("trip issued while user block active");
   a_unr_trips: assert property (
      !user_block_input |=>
         ((phase_trip_out & $past(dec.unr)) == $past(dec.unr)))
      else $error("unrestrained start did not trip its phase");
   a_general_cover: assert property (
      ##1 (general_trip_out == |phase_trip_out))
      else $error("general trip disagrees with phase trips");
   a_bias_largest: assert property (
      ##1 (bias >= $past(lmag[1]) && bias >= $past(rmag[2])))
      else $error("bias current below a phase magnitude");
   a_restraint_or: assert property (
      (h5_status[2] && !user_block_input) |=> general_h5_restraint)
      else $error("fifth harmonic general restraint missed");
endmodule

// ==== ldr_pkg.sv ====
// Shared constants, register map and carrier types of the decision block.
package ldr_pkg;

   // Clock rate and restraint timing.
   localparam int CLK_MHZ       = 125;
   localparam int QUAL_MS       = 25;
   localparam int DROP_MS       = 15;
   localparam int CYC_PER_MS    = CLK_MHZ * 1000;
   localparam int QUAL_CYC      = QUAL_MS * CYC_PER_MS;
   localparam int DROP_CYC      = DROP_MS * CYC_PER_MS;
   localparam int CNT_W         = 22;

   // Arithmetic scaling.
   localparam int PCT_FULL      = 100;
   localparam int SCALE_SHIFT   = 8;
   localparam int IN_W          = 16;
   localparam int WIDE_W        = 25;
   localparam int PROD_W        = 40;

   // Register offsets (byte addresses, one word each).
   localparam logic [7:0] ADDR_LOCAL_RATIO  = 8'h00;
   localparam logic [7:0] ADDR_REMOTE_RATIO = 8'h04;
   localparam logic [7:0] ADDR_H2_SET       = 8'h08;
   localparam logic [7:0] ADDR_H5_SET       = 8'h0C;
   localparam logic [7:0] ADDR_UNR_LIMIT    = 8'h10;
   localparam logic [7:0] ADDR_CHAR_BASE    = 8'h14;
   localparam logic [7:0] ADDR_CHAR_SLOPE   = 8'h18;
   localparam logic [7:0] ADDR_STATUS       = 8'h1C;

   // Reset values of the settings.
   localparam logic [15:0] RST_RATIO       = 16'h0064;
   localparam logic [7:0]  RST_H2_SET      = 8'h0F;
   localparam logic [7:0]  RST_H5_SET      = 8'h19;
   localparam logic [24:0] RST_UNR_LIMIT   = 25'h1FFFFFF;
   localparam logic [24:0] RST_CHAR_BASE   = 25'h0000100;
   localparam logic [7:0]  RST_CHAR_SLOPE  = 8'h1E;
   localparam logic [15:0] SCALE_UNITY     = 16'h0100;

   // Status word field positions.
   localparam int ST_TRIP   = 0;
   localparam int ST_START  = 3;
   localparam int ST_UNR    = 6;
   localparam int ST_H2     = 9;
   localparam int ST_H5     = 12;
   localparam int ST_GEN    = 15;
   localparam int ST_HBLK   = 16;

   typedef struct packed {
      logic signed [IN_W-1:0] re;
      logic signed [IN_W-1:0] im;
   } ldr_phasor_t;

   typedef struct packed {
      logic signed [WIDE_W-1:0] re;
      logic signed [WIDE_W-1:0] im;
   } ldr_wide_t;

   typedef struct packed {
      logic [2:0] start;
      logic [2:0] unr;
   } ldr_decision_t;

   typedef enum logic [1:0] {
      RS_IDLE  = 2'b00,
      RS_EARLY = 2'b01,
      RS_QUAL  = 2'b11,
      RS_HOLD  = 2'b10
   } ldr_rstate_t;

endpackage

// ==== ldr_restraint_timer.sv ====
// One harmonic restraint status with 25 ms qualification and 15 ms drop-off.
`timescale 1ns/1ns
module ldr_restraint_timer #(
   parameter int QUAL_CYCLES = ldr_pkg::QUAL_CYC,
   parameter int DROP_CYCLES = ldr_pkg::DROP_CYC
) (
   input  wire logic mclk,    // Evaluation clock.
   input  wire logic rst,     // Synchronous reset, active high.
   input  wire logic high,    // Harmonic ratio above its setting.
   output logic      status   // Restraint status.
);
   ldr_pkg::ldr_rstate_t           state;
   ldr_pkg::ldr_rstate_t           next_state;
   logic [ldr_pkg::CNT_W-1:0]      cnt;

   localparam int CW = ldr_pkg::CNT_W;
   localparam logic [CW-1:0] QUAL_LAST = CW'(QUAL_CYCLES - 1);
   localparam logic [CW-1:0] DROP_LAST = CW'(DROP_CYCLES - 1);

   always_comb begin
      next_state = state;
      case (state)
         ldr_pkg::RS_IDLE: begin
            if (high) next_state = ldr_pkg::RS_EARLY;
         end
         ldr_pkg::RS_EARLY: begin
            if (!high) next_state = ldr_pkg::RS_IDLE;
            else if (cnt == QUAL_LAST) next_state = ldr_pkg::RS_QUAL;
         end
         ldr_pkg::RS_QUAL: begin
            if (!high) next_state = ldr_pkg::RS_HOLD;
         end
         ldr_pkg::RS_HOLD: begin
            if (high) next_state = ldr_pkg::RS_QUAL;
            else if (cnt == DROP_LAST) next_state = ldr_pkg::RS_IDLE;
         end
         default: next_state = ldr_pkg::RS_IDLE;
      endcase
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         state  <= ldr_pkg::RS_IDLE;
         status <= 1'b0;
      end else begin
         state  <= next_state;
         status <= (next_state != ldr_pkg::RS_IDLE);
      end
   end

   // The counter restarts on every state change so each phase times alone.
   always_ff @(posedge mclk) begin
      if (rst || next_state != state) cnt <= '0;
      else cnt <= cnt + 1'b1;
   end

   default clocking cb @(posedge mclk); endclocking
   default disable iff (rst);

   sequence s_qualified_fall;
      state == ldr_pkg::RS_QUAL && !high;
   endsequence

   a_status_rise_now: assert property (
      (state == ldr_pkg::RS_IDLE && high) |=> status)
      else $error("restraint status did not rise after high ratio");
   a_early_end_clear: assert property (
      (state == ldr_pkg::RS_EARLY && !high) |=> !status)
      else $error("restraint status held after an unqualified episode");
   a_dropoff_hold: assert property (
      s_qualified_fall |=> status [*8])
      else $error("qualified restraint status dropped without delay");
endmodule

// ==== ldr_shift_src.sv ====
// Model of the vector shift stage that feeds compensated phasors.
`timescale 1ns/1ns
module ldr_shift_src (
   input  wire logic                  mclk, // Evaluation clock.
   output ldr_pkg::ldr_phasor_t [2:0] loc,  // Local shifted vectors.
   output ldr_pkg::ldr_phasor_t [2:0] rem,  // Remote shifted vectors.
   output ldr_pkg::ldr_phasor_t [2:0] h2,   // 2nd harmonic vectors.
   output ldr_pkg::ldr_phasor_t [2:0] h5    // 5th harmonic vectors.
);
   initial begin
      loc = '0;
      rem = '0;
      h2  = '0;
      h5  = '0;
   end
   // inward positive polarity
   // Both sides post current into the zone as positive, so a through load
   // shows as equal and opposite values on one phase.
   task automatic put(input int p, input logic signed [15:0] l, r, a, b);
      @(posedge mclk);
      loc[p] <= '{re: l, im: 16'sh0000};
      rem[p] <= '{re: r, im: 16'sh0000};
      h2[p]  <= '{re: a, im: 16'sh0000};
      h5[p]  <= '{re: b, im: 16'sh0000};
   endtask
endmodule

// ==== ldr_top_tb.sv ====
// Self-checking bench of the line differential restraint and trip block.
`timescale 1ns/1ns
module ldr_top_tb;
   logic                       mclk, rst, reg_wr, reg_rd, blk;
   logic [7:0]                 reg_addr;
   logic [31:0]                reg_wdata, reg_rdata, d;
   ldr_pkg::ldr_phasor_t [2:0] loc, rem, h2, h5;
   logic [2:0]                 trip, bst;
   logic                       gtr, hbk, g2, g5, gun;
   logic [10:0]                obs;
   int                         num_errors = 0;
   int                         checks = 0;
   localparam logic [31:0] RV [7] = '{32'h64, 32'h64, 32'h0F, 32'h19,
                                      32'h1FFFFFF, 32'h100, 32'h1E};
   assign obs = {gun, g5, g2, hbk, gtr, bst, trip};
   ldr_shift_src src (.mclk(mclk), .loc(loc), .rem(rem), .h2(h2), .h5(h5));
   ldr_top #(.QUAL_CYCLES(40), .DROP_CYCLES(20)) uut (
      .mclk(mclk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .local_shifted(loc), .remote_shifted(rem), .diff_h2(h2),
      .diff_h5(h5), .user_block_input(blk), .phase_trip_out(trip),
      .general_trip_out(gtr), .harmonic_block_out(hbk),
      .general_h2_restraint(g2), .general_h5_restraint(g5),
      .general_unr_start(gun), .biased_start(bst));
   initial begin
      mclk = 1'b0;
      forever #4 mclk = ~mclk;
   end
   task automatic give_verdict();
      $display("Checks %0d, errors %0d", checks, num_errors);
      if (num_errors == 0 && checks > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         num_errors++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic co(input logic [10:0] e);
      cmp({21'h0, obs}, {21'h0, e});
   endtask
   task automatic wt(input int n);
      repeat (n) @(posedge mclk);
      #1;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      @(posedge mclk);
      reg_addr <= a;
      reg_wdata <= v;
      reg_wr <= 1'b1;
      @(posedge mclk);
      reg_wr <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] v);
      @(posedge mclk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge mclk);
      reg_rd <= 1'b0;
      #1 v = reg_rdata;
   endtask
   task automatic t_regs();
      for (int i = 0; i < 7; i++) begin
         rd(8'(4 * i), d);
         cmp(d, RV[i]);
      end
      rd(8'h20, d);
      cmp(d, 32'h0);
      wr(8'h1C, 32'hFFFF);
      rd(8'h1C, d);
      cmp(d, 32'h0);
   endtask
   task automatic t_fault();
      for (int p = 0; p < 3; p++) begin
         src.put(p, 16'sd1000, 16'sd0, 16'sd0, 16'sd0);
         wt(8);
         co({4'h0, 1'b1, 3'(1 << p), 3'(1 << p)});
         src.put(p, 16'sd1000, -16'sd1000, 16'sd0, 16'sd0);
         wt(8);
         co(11'h000);
         src.put(p, 16'sd0, 16'sd0, 16'sd0, 16'sd0);
      end
   endtask
   task automatic t_ratio();
      src.put(0, 16'sd600, 16'sd0, 16'sd0, 16'sd0);
      wt(8);
      co(11'h049);
      wr(8'h00, 32'hC8);
      wt(8);
      co(11'h000);
      src.put(0, 16'sd0, 16'sd200, 16'sd0, 16'sd0);
      wr(8'h04, 32'h32);
      wt(8);
      co(11'h049);
      wr(8'h04, 32'h64);
      wt(8);
      co(11'h000);
      wr(8'h00, 32'h64);
      src.put(0, 16'sd0, 16'sd0, 16'sd0, 16'sd0);
   endtask
   task automatic t_unr();
      wr(8'h10, 32'h7D0);
      src.put(1, 16'sd3000, 16'sd0, 16'sd1000, 16'sd0);
      wt(8);
      co({1'b1, 1'b0, 1'b1, 1'b1, 1'b1, 3'h2, 3'h2});
      rd(8'h1C, d);
      cmp(d, 32'h00018492);
      @(posedge mclk);
      blk <= 1'b1;
      wt(8);
      co({1'b1, 1'b0, 1'b1, 1'b1, 1'b0, 3'h2, 3'h0});
      @(posedge mclk);
      blk <= 1'b0;
      src.put(1, 16'sd0, 16'sd0, 16'sd0, 16'sd0);
      wr(8'h10, 32'h1FFFFFF);
      wt(8);
      co(11'h000);
   endtask
   task automatic t_harm(input int n, input bit lng);
      int p;
      p = 2 * n;
      if (n == 0) src.put(p, 16'sd1000, 16'sd0, 16'sd300, 16'sd0);
      else src.put(p, 16'sd1000, 16'sd0, 16'sd0, 16'sd300);
      wt(8);
      co({1'b0, n == 1, n == 0, 1'b1, 1'b0, 3'(1 << p), 3'h0});
      wt(lng ? 60 : 2);
      src.put(p, 16'sd1000, 16'sd0, 16'sd0, 16'sd0);
      wt(10);
      if (lng) begin
         co({1'b0, n == 1, n == 0, 1'b1, 1'b0, 3'(1 << p), 3'h0});
      end else begin
         co({4'h0, 1'b1, 3'(1 << p), 3'(1 << p)});
      end
      wt(30);
      co({4'h0, 1'b1, 3'(1 << p), 3'(1 << p)});
      src.put(p, 16'sd0, 16'sd0, 16'sd0, 16'sd0);
      wt(8);
   endtask
   initial begin
      rst = 1'b1;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_addr = 8'h00;
      reg_wdata = 32'h0;
      blk = 1'b0;
      repeat (4) @(posedge mclk);
      rst <= 1'b0;
      t_regs();
      t_fault();
      t_ratio();
      t_unr();
      for (int n = 0; n < 2; n++) begin
         t_harm(n, 1'b0);
         t_harm(n, 1'b1);
      end
      give_verdict();
   end
   // A hang is cut short here and counts as a mismatch.
   initial begin
      #200000;
      num_errors++;
      give_verdict();
   end
endmodule
